// ==== hw/compare_skip_branch_unit.sv ====
// Compare, conditional skip and conditional branch execution unit
`timescale 1ns/100ps

// Notes on behaviour
// - Compares subtract register, register plus carry, or constant; set Z,N,V,C,H; one cycle.
// - Register-bit skips test one register bit; skip moves PC 2 or 3; 1-3 cycles.
// - I/O-bit skips test one I/O bit; flags untouched; 1, 2 or 3 cycles.
// - Generic branches test status bit chosen by operand; taken gives PC plus offset plus one.
// - Equal branches on Z set, not-equal on Z clear; one or two cycles.
// - Carry branches on C set or C clear; one or two cycles.
// - Same-or-higher acts as carry clear, lower acts as carry set.
// - Minus branches on N set, plus on N clear; one or two cycles.
// - Signed greater-or-equal when N xor V is zero, less-than when one.
// - Half-carry branches on H set or H clear; one or two cycles.
// - T-flag branches on T set or T clear; no flags modified.
// - Overflow branches on V set or V clear; one or two cycles.
// - Interrupt-state branches on I set or I clear; one or two cycles.
module compare_skip_branch_unit (
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        start_i,
  input  wire logic [4:0]                  op_i,
  input  wire logic [csb_pkg::DATA_W-1:0]  operand_a_i,
  input  wire logic [csb_pkg::DATA_W-1:0]  operand_b_i,
  input  wire logic [csb_pkg::DATA_W-1:0]  io_data_i,
  input  wire logic [csb_pkg::BIT_W-1:0]   bit_sel_i,
  input  wire logic [csb_pkg::OFF_W-1:0]   offset_i,
  input  wire logic [csb_pkg::PC_W-1:0]    pc_i,
  input  wire logic                        next_two_word_i,
  input  wire logic [csb_pkg::DATA_W-1:0]  status_flags_i,
  output logic                             busy_o,
  output logic                             done_o,
  output logic                             taken_o,
  output logic [csb_pkg::PC_W-1:0]         pc_next_o,
  output logic [csb_pkg::DATA_W-1:0]       status_flags_o,
  output logic                             flags_we_o
);

  // Branch condition for every branch opcode; other codes never branch
  function automatic logic branch_cond(input logic [4:0] op,
                                       input logic [csb_pkg::DATA_W-1:0] f,
                                       input logic [csb_pkg::BIT_W-1:0] sel);
    logic c;
    c = 1'b0;
    unique case (op)
      csb_pkg::op_branch_flag_set:        c = f[sel];
      csb_pkg::op_branch_flag_clear:      c = ~f[sel];
      csb_pkg::op_branch_equal:           c = f[csb_pkg::FLAG_Z];
      csb_pkg::op_branch_not_equal:       c = ~f[csb_pkg::FLAG_Z];
      csb_pkg::op_branch_carry_set:       c = f[csb_pkg::FLAG_C];
      csb_pkg::op_branch_carry_clear:     c = ~f[csb_pkg::FLAG_C];
      csb_pkg::op_branch_lower:           c = f[csb_pkg::FLAG_C];
      csb_pkg::op_branch_same_higher:     c = ~f[csb_pkg::FLAG_C];
      csb_pkg::op_branch_minus:           c = f[csb_pkg::FLAG_N];
      csb_pkg::op_branch_plus:            c = ~f[csb_pkg::FLAG_N];
      csb_pkg::op_branch_signed_ge:       c = ~(f[csb_pkg::FLAG_N] ^ f[csb_pkg::FLAG_V]);
      csb_pkg::op_branch_signed_lt:       c = f[csb_pkg::FLAG_N] ^ f[csb_pkg::FLAG_V];
      csb_pkg::op_branch_halfcarry_set:   c = f[csb_pkg::FLAG_H];
      csb_pkg::op_branch_halfcarry_clear: c = ~f[csb_pkg::FLAG_H];
      csb_pkg::op_branch_tflag_set:       c = f[csb_pkg::FLAG_T];
      csb_pkg::op_branch_tflag_clear:     c = ~f[csb_pkg::FLAG_T];
      csb_pkg::op_branch_overflow_set:    c = f[csb_pkg::FLAG_V];
      csb_pkg::op_branch_overflow_clear:  c = ~f[csb_pkg::FLAG_V];
      csb_pkg::op_branch_irq_enabled:     c = f[csb_pkg::FLAG_I];
      csb_pkg::op_branch_irq_disabled:    c = ~f[csb_pkg::FLAG_I];
      default:                            c = 1'b0;
    endcase
    return c;
  endfunction

  csb_pkg::state_t                 state_q;
  csb_pkg::state_t                 state_d;
  logic                            busy_q;
  logic                            done_q;
  logic                            taken_q;
  logic [csb_pkg::PC_W-1:0]        pc_next_q;
  logic [csb_pkg::DATA_W-1:0]      flags_q;
  logic                            flags_we_q;

  logic                            accept_w;
  logic                            is_cmp_w;
  logic                            is_skip_reg_w;
  logic                            is_skip_io_w;
  logic                            is_skip_w;
  logic                            is_branch_w;
  logic                            want_set_w;
  logic                            test_bit_w;
  logic                            skip_w;
  logic                            branch_w;
  logic                            borrow_w;
  logic [csb_pkg::DATA_W-1:0]      subtrahend_w;
  logic [csb_pkg::DATA_W-1:0]      diff_w;
  logic                            c_w;
  logic                            h_w;
  logic                            v_w;
  logic                            n_w;
  logic                            z_w;
  logic [csb_pkg::DATA_W-1:0]      cmp_flags_w;
  logic [csb_pkg::PC_W-1:0]        offset_ext_w;
  logic [csb_pkg::PC_W-1:0]        skip_step_w;
  logic [csb_pkg::PC_W-1:0]        pc_calc_w;
  logic [csb_pkg::PC_W-1:0]        branch_target_w;
  logic [csb_pkg::PC_W-1:0]        skip_target_w;
  logic [csb_pkg::PC_W-1:0]        seq_target_w;
  logic [1:0]                      skip_extra_w;
  logic                            busy_d;
  logic                            done_d;
  logic [1:0]                      extra_w;

  assign accept_w = start_i & (state_q == csb_pkg::st_idle);

  // Opcode class decode
  assign is_cmp_w      = (op_i == csb_pkg::op_compare_registers) |
                         (op_i == csb_pkg::op_compare_with_carry_in) |
                         (op_i == csb_pkg::op_compare_immediate);
  assign is_skip_reg_w = (op_i == csb_pkg::op_skip_reg_bit_clear) | (op_i == csb_pkg::op_skip_reg_bit_set);
  assign is_skip_io_w  = (op_i == csb_pkg::op_skip_io_bit_clear) | (op_i == csb_pkg::op_skip_io_bit_set);
  assign is_skip_w     = is_skip_reg_w | is_skip_io_w;
  assign is_branch_w   = (op_i >= csb_pkg::op_branch_flag_set) & (op_i <= csb_pkg::op_branch_irq_disabled);

  // Compare operand: immediate arrives on operand_b as well, no borrow
  assign borrow_w     = (op_i == csb_pkg::op_compare_with_carry_in) & status_flags_i[csb_pkg::FLAG_C];
  assign subtrahend_w = operand_b_i;

  flag_sub8 u_sub (
    .minuend_i    (operand_a_i),
    .subtrahend_i (subtrahend_w),
    .borrow_i     (borrow_w),
    .diff_o       (diff_w),
    .carry_o      (c_w),
    .half_o       (h_w),
    .overflow_o   (v_w),
    .negative_o   (n_w),
    .zero_o       (z_w)
  );

  // Difference is dropped; only the five flags change, S and the rest pass through
  always_comb begin
    cmp_flags_w                  = status_flags_i;
    cmp_flags_w[csb_pkg::FLAG_C] = c_w;
    cmp_flags_w[csb_pkg::FLAG_Z] = z_w;
    cmp_flags_w[csb_pkg::FLAG_N] = n_w;
    cmp_flags_w[csb_pkg::FLAG_V] = v_w;
    cmp_flags_w[csb_pkg::FLAG_H] = h_w;
  end

  // Skip test selects register or I/O bit
  assign want_set_w = (op_i == csb_pkg::op_skip_reg_bit_set) | (op_i == csb_pkg::op_skip_io_bit_set);
  assign test_bit_w = is_skip_io_w ? io_data_i[bit_sel_i] : operand_a_i[bit_sel_i];
  assign skip_w     = is_skip_w & (test_bit_w == want_set_w);
  assign branch_w   = is_branch_w & branch_cond(op_i, status_flags_i, bit_sel_i);

  // Signed word displacement, sign-extended to the PC width
  assign offset_ext_w = {{(csb_pkg::PC_W-csb_pkg::OFF_W){offset_i[csb_pkg::OFF_W-1]}}, offset_i};
  assign skip_step_w  = next_two_word_i ? csb_pkg::PC_STEP_SKIP2 : csb_pkg::PC_STEP_SKIP1;
  assign branch_target_w = pc_i + offset_ext_w + csb_pkg::PC_STEP_ONE;
  assign skip_target_w   = pc_i + skip_step_w;
  assign seq_target_w    = pc_i + csb_pkg::PC_STEP_ONE;
  // Wraps at the top of the word space, like the core counter
  assign pc_calc_w       = branch_w ? branch_target_w :
                           skip_w   ? skip_target_w   :
                                      seq_target_w;

  // Untaken and compares finish at once; taken branch one more, skip one or two more
  assign skip_extra_w = next_two_word_i ? csb_pkg::EXTRA_TWO : csb_pkg::EXTRA_ONE;
  assign extra_w      = branch_w ? csb_pkg::EXTRA_ONE :
                        skip_w   ? skip_extra_w :
                                   csb_pkg::EXTRA_NONE;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      csb_pkg::st_idle: begin
        if (accept_w && extra_w == csb_pkg::EXTRA_TWO) begin
          state_d = csb_pkg::st_wait2;
        end else if (accept_w && extra_w == csb_pkg::EXTRA_ONE) begin
          state_d = csb_pkg::st_wait1;
        end
      end
      csb_pkg::st_wait2: state_d = csb_pkg::st_wait1;
      csb_pkg::st_wait1: state_d = csb_pkg::st_idle;
      default:           state_d = csb_pkg::st_idle;
    endcase
  end

  // Busy mirrors the wait states; done marks the last cycle of each accepted instruction
  assign busy_d = (state_d != csb_pkg::st_idle);
  assign done_d = (accept_w && extra_w == csb_pkg::EXTRA_NONE) || (state_q == csb_pkg::st_wait1);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= csb_pkg::st_idle;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
    end
  end

  // Results are latched on every accepted start; flags written only by compares
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      taken_q    <= 1'b0;
      pc_next_q  <= csb_pkg::PC_RESET;
      flags_q    <= csb_pkg::FLAGS_RESET;
      flags_we_q <= 1'b0;
    end else begin
      flags_we_q <= accept_w & is_cmp_w;
      if (accept_w) begin
        taken_q   <= branch_w | skip_w;
        pc_next_q <= pc_calc_w;
        flags_q   <= is_cmp_w ? cmp_flags_w : status_flags_i;
      end
    end
  end

  assign busy_o         = busy_q;
  assign done_o         = done_q;
  assign taken_o        = taken_q;
  assign pc_next_o      = pc_next_q;
  assign status_flags_o = flags_q;
  assign flags_we_o     = flags_we_q;

endmodule // compare_skip_branch_unit

// ==== hw/csb_pkg.sv ====
// Shared constants, opcodes and states for the compare, skip and branch unit
package csb_pkg;

  localparam int DATA_W = 8;
  localparam int NIB_W  = 4;
  localparam int PC_W   = 16;
  localparam int OFF_W  = 7;
  localparam int BIT_W  = 3;

  // Status flag bit positions
  localparam logic [BIT_W-1:0] FLAG_C = 3'h0;
  localparam logic [BIT_W-1:0] FLAG_Z = 3'h1;
  localparam logic [BIT_W-1:0] FLAG_N = 3'h2;
  localparam logic [BIT_W-1:0] FLAG_V = 3'h3;
  localparam logic [BIT_W-1:0] FLAG_S = 3'h4;
  localparam logic [BIT_W-1:0] FLAG_H = 3'h5;
  localparam logic [BIT_W-1:0] FLAG_T = 3'h6;
  localparam logic [BIT_W-1:0] FLAG_I = 3'h7;

  localparam logic [PC_W-1:0]   PC_STEP_ONE   = 16'h0001;
  localparam logic [PC_W-1:0]   PC_STEP_SKIP1 = 16'h0002;
  localparam logic [PC_W-1:0]   PC_STEP_SKIP2 = 16'h0003;
  localparam logic [PC_W-1:0]   PC_RESET      = 16'h0000;
  localparam logic [DATA_W-1:0] FLAGS_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO     = 8'h00;

  // Extra cycles beyond the first
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE  = 2'h1;
  localparam logic [1:0] EXTRA_TWO  = 2'h2;

  typedef enum logic [4:0] {
    op_nop                 = 5'h00,
    op_compare_registers   = 5'h01,
    op_compare_with_carry_in = 5'h02,
    op_compare_immediate   = 5'h03,
    op_skip_reg_bit_clear  = 5'h04,
    op_skip_reg_bit_set    = 5'h05,
    op_skip_io_bit_clear   = 5'h06,
    op_skip_io_bit_set     = 5'h07,
    op_branch_flag_set     = 5'h08,
    op_branch_flag_clear   = 5'h09,
    op_branch_equal        = 5'h0A,
    op_branch_not_equal    = 5'h0B,
    op_branch_carry_set    = 5'h0C,
    op_branch_carry_clear  = 5'h0D,
    op_branch_same_higher  = 5'h0E,
    op_branch_lower        = 5'h0F,
    op_branch_minus        = 5'h10,
    op_branch_plus         = 5'h11,
    op_branch_signed_ge    = 5'h12,
    op_branch_signed_lt    = 5'h13,
    op_branch_halfcarry_set   = 5'h14,
    op_branch_halfcarry_clear = 5'h15,
    op_branch_tflag_set    = 5'h16,
    op_branch_tflag_clear  = 5'h17,
    op_branch_overflow_set   = 5'h18,
    op_branch_overflow_clear = 5'h19,
    op_branch_irq_enabled  = 5'h1A,
    op_branch_irq_disabled = 5'h1B
  } op_t;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_wait1 = 2'b01,
    st_wait2 = 2'b11
  } state_t;

endpackage

// ==== hw/flag_sub8.sv ====
// Eight-bit subtractor with borrow in and full flag outputs
`timescale 1ns/100ps
module flag_sub8 (
  input  wire logic [csb_pkg::DATA_W-1:0] minuend_i,
  input  wire logic [csb_pkg::DATA_W-1:0] subtrahend_i,
  input  wire logic                       borrow_i,
  output logic      [csb_pkg::DATA_W-1:0] diff_o,
  output logic                            carry_o,
  output logic                            half_o,
  output logic                            overflow_o,
  output logic                            negative_o,
  output logic                            zero_o
);

  logic [csb_pkg::DATA_W:0] wide_w;
  logic [csb_pkg::NIB_W:0]  low_w;

  // Extra top bit catches the borrow out
  assign wide_w     = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {{csb_pkg::DATA_W{1'b0}}, borrow_i};
  assign low_w      = {1'b0, minuend_i[csb_pkg::NIB_W-1:0]} - {1'b0, subtrahend_i[csb_pkg::NIB_W-1:0]} -
                      {{csb_pkg::NIB_W{1'b0}}, borrow_i};
  assign diff_o     = wide_w[csb_pkg::DATA_W-1:0];
  assign carry_o    = wide_w[csb_pkg::DATA_W];
  assign half_o     = low_w[csb_pkg::NIB_W];
  assign negative_o = diff_o[csb_pkg::DATA_W-1];
  assign zero_o     = (diff_o == csb_pkg::DATA_ZERO);
  assign overflow_o = (minuend_i[csb_pkg::DATA_W-1] & ~subtrahend_i[csb_pkg::DATA_W-1] & ~negative_o) |
                      (~minuend_i[csb_pkg::DATA_W-1] & subtrahend_i[csb_pkg::DATA_W-1] & negative_o);

endmodule // flag_sub8

// ==== tb/csb_unit_chk.sv ====
// Port-level checks for the compare, skip and branch unit
`timescale 1ns/100ps
module csb_unit_chk (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        start_i,
  input wire logic [4:0]  op_i,
  input wire logic [7:0]  operand_a_i,
  input wire logic [7:0]  operand_b_i,
  input wire logic [7:0]  io_data_i,
  input wire logic [2:0]  bit_sel_i,
  input wire logic [6:0]  offset_i,
  input wire logic [15:0] pc_i,
  input wire logic        next_two_word_i,
  input wire logic [7:0]  status_flags_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        taken_o,
  input wire logic [15:0] pc_next_o,
  input wire logic [7:0]  status_flags_o,
  input wire logic        flags_we_o
);
  wire logic        acc_w = start_i && !busy_o;
  wire logic        nxv_w = status_flags_i[2] ^ status_flags_i[3];
  wire logic        t_w   = status_flags_i[6];
  wire logic [15:0] inc_w = pc_i + 16'h0001;
  wire logic [15:0] tgt_w = pc_i + {{9{offset_i[6]}}, offset_i} + 16'h0001;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_cmp; acc_w && op_i inside {5'h01, 5'h02, 5'h03}; endsequence
  // Second cycle busy, then a lone done pulse
  sequence s_two_wait; busy_o && !done_o ##1 done_o && !busy_o; endsequence
  cmp_one_cycle_a: assert property (s_cmp |=> done_o && flags_we_o && !taken_o && pc_next_o == $past(inc_w))
    else $error("compare completion wrong");
  cmp_zero_carry_a: assert property (acc_w && op_i == 5'h01 |=>
    status_flags_o[1] == ($past(operand_a_i) == $past(operand_b_i)) &&
    status_flags_o[0] == ($past(operand_a_i) < $past(operand_b_i))) else $error("compare flags wrong");
  skip_reg_a: assert property (acc_w && op_i == 5'h05 && operand_a_i[bit_sel_i] |=> taken_o &&
    pc_next_o == $past(pc_i) + ($past(next_two_word_i) ? 16'h0003 : 16'h0002)) else $error("register skip wrong");
  skip_io_a: assert property (acc_w && op_i == 5'h06 && !io_data_i[bit_sel_i] |=> taken_o && !flags_we_o &&
    status_flags_o == $past(status_flags_i)) else $error("io skip wrong");
  skip_wait_a: assert property (acc_w && op_i == 5'h07 && io_data_i[bit_sel_i] && next_two_word_i
    |=> busy_o ##1 s_two_wait) else $error("two word skip timing wrong");
  flag_branch_a: assert property (acc_w && op_i == 5'h08 && status_flags_i[bit_sel_i] |=> taken_o &&
    pc_next_o == $past(tgt_w)) else $error("branch target wrong");
  not_equal_a: assert property (acc_w && op_i == 5'h0B && status_flags_i[1] |=>
    done_o && !taken_o && !busy_o && pc_next_o == $past(inc_w)) else $error("untaken branch wrong");
  carry_taken_a: assert property (acc_w && op_i == 5'h0C && status_flags_i[0] |=> s_two_wait)
    else $error("taken branch timing wrong");
  signed_ge_a: assert property (acc_w && op_i == 5'h12 |=> taken_o == !$past(nxv_w))
    else $error("signed branch wrong");
  tflag_clear_a: assert property (acc_w && op_i == 5'h17 |=> taken_o != $past(t_w) && !flags_we_o)
    else $error("t flag branch wrong");
endmodule // csb_unit_chk

bind compare_skip_branch_unit csb_unit_chk chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i),
  .op_i(op_i), .operand_a_i(operand_a_i), .operand_b_i(operand_b_i), .io_data_i(io_data_i),
  .bit_sel_i(bit_sel_i), .offset_i(offset_i), .pc_i(pc_i), .next_two_word_i(next_two_word_i),
  .status_flags_i(status_flags_i), .busy_o(busy_o), .done_o(done_o), .taken_o(taken_o),
  .pc_next_o(pc_next_o), .status_flags_o(status_flags_o), .flags_we_o(flags_we_o));

// ==== tb/tb_top.sv ====
// Self-checking bench for the compare, skip and branch unit
`timescale 1ns/100ps
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_n_i, start_i, next_two_word_i, busy_o, done_o, taken_o, flags_we_o;
  logic [4:0]  op_i;
  logic [7:0]  operand_a_i, operand_b_i, io_data_i, status_flags_i, status_flags_o;
  logic [2:0]  bit_sel_i;
  logic [6:0]  offset_i;
  logic [15:0] pc_i, pc_next_o;
  int          num_errors = 0;
  int          checked = 0;
  logic [7:0]  va [5] = '{8'h10, 8'h00, 8'h80, 8'h7F, 8'h10};
  logic [7:0]  vb [5] = '{8'h10, 8'h01, 8'h01, 8'hFF, 8'h0F};
  logic [7:0]  vf [5] = '{8'h00, 8'hFF, 8'h01, 8'hFE, 8'h01};
  logic [7:0]  bf [6] = '{8'h00, 8'hFF, 8'h55, 8'hAA, 8'h04, 8'h08};

  always #12.5 clock_i = ~clock_i;

  compare_skip_branch_unit dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
    .operand_a_i(operand_a_i), .operand_b_i(operand_b_i), .io_data_i(io_data_i), .bit_sel_i(bit_sel_i),
    .offset_i(offset_i), .pc_i(pc_i), .next_two_word_i(next_two_word_i), .status_flags_i(status_flags_i),
    .busy_o(busy_o), .done_o(done_o), .taken_o(taken_o), .pc_next_o(pc_next_o),
    .status_flags_o(status_flags_o), .flags_we_o(flags_we_o));

  task automatic end_of_test();
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic cond(input logic [4:0] op, input logic [7:0] f, input logic [2:0] s);
    logic v;
    case (op)
      5'h08, 5'h09: v = f[s];
      5'h0A, 5'h0B: v = f[1];
      5'h0C, 5'h0D, 5'h0E, 5'h0F: v = f[0];
      5'h10, 5'h11: v = f[2];
      5'h12, 5'h13: v = f[2] ^ f[3];
      5'h14, 5'h15: v = f[5];
      5'h16, 5'h17: v = f[6];
      5'h18, 5'h19: v = f[3];
      default: v = f[7];
    endcase
    // Same-or-higher and greater-or-equal take the cleared sense on even codes
    return v == (~op[0] ^ (op inside {5'h0E, 5'h0F, 5'h12, 5'h13}));
  endfunction

  task automatic run(input logic [4:0] op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] io,
                     input logic [2:0] s, input logic [6:0] k, input logic [15:0] pc, input logic two,
                     input logic [7:0] f);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] ef;
    logic       tk;
    logic       cin;
    int         n;
    int         en;
    ef = f;
    tk = 1'b0;
    cin = (op == 5'h02) & f[0];
    d = {1'b0, a} - {1'b0, b} - 9'(cin);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cin);
    if (op inside {[5'h01:5'h03]}) begin
      ef[0] = d[8];
      ef[1] = (d[7:0] == 8'h00);
      ef[2] = d[7];
      ef[3] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
      ef[5] = h[4];
    end
    if (op inside {[5'h04:5'h07]}) tk = (op[1] ? io[s] : a[s]) == op[0];
    if (op inside {[5'h08:5'h1B]}) tk = cond(op, f, s);
    en = tk ? (op < 5'h08 ? 2 + int'(two) : 2) : 1;
    @(negedge clock_i);
    op_i = op;
    operand_a_i = a;
    operand_b_i = b;
    io_data_i = io;
    bit_sel_i = s;
    offset_i = k;
    pc_i = pc;
    next_two_word_i = two;
    status_flags_i = f;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    n = 1;
    while (done_o !== 1'b1 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    check(16'(n), 16'(en));
    check(16'(taken_o), 16'(tk));
    check(pc_next_o, tk ? (op < 5'h08 ? pc + 16'h0002 + 16'(two) : pc + {{9{k[6]}}, k} + 16'h0001)
                        : pc + 16'h0001);
    check(16'(status_flags_o), 16'(ef));
    check(16'(flags_we_o), 16'(op inside {[5'h01:5'h03]}));
  endtask

  initial begin
    {start_i, next_two_word_i, op_i, operand_a_i, operand_b_i, io_data_i, bit_sel_i, offset_i, pc_i} = '0;
    status_flags_i = 8'h00;
    rst_n_i = 1'b0;
    repeat (16) @(posedge clock_i);
    check(pc_next_o, 16'h0000);
    check(16'({busy_o, done_o, taken_o, flags_we_o}), 16'h0000);
    @(negedge clock_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 5; i++)
      for (int o = 1; o < 4; o++) run(5'(o), va[i], vb[i], 8'h00, 3'h0, 7'h00, 16'h0100, 1'b0, vf[i]);
    // Start near the top so a skip also wraps the counter
    for (int o = 4; o < 8; o++)
      for (int s = 0; s < 8; s++)
        for (int t = 0; t < 2; t++) run(5'(o), 8'hA5, 8'h00, 8'h5A, 3'(s), 7'h00, 16'hFFFE, 1'(t), 8'hFF);
    for (int o = 8; o < 28; o++)
      for (int j = 0; j < 6; j++) run(5'(o), 8'h00, 8'h00, 8'h00, 3'(j + o), j[0] ? 7'h40 : 7'h3F, 16'h0020, 1'b0, bf[j]);
    for (int o = 28; o < 32; o++) run(5'(o), 8'h12, 8'h34, 8'h00, 3'h0, 7'h10, 16'h1234, 1'b1, 8'hFF);
    // Start held through a two-word skip is refused until done, then the compare lands
    @(negedge clock_i);
    op_i = 5'h07;
    io_data_i = 8'h01;
    bit_sel_i = 3'h0;
    next_two_word_i = 1'b1;
    pc_i = 16'h0200;
    operand_a_i = 8'h00;
    operand_b_i = 8'h00;
    status_flags_i = 8'h00;
    start_i = 1'b1;
    @(negedge clock_i);
    op_i = 5'h01;
    check(16'(busy_o), 16'h0001);
    @(negedge clock_i);
    check(16'(flags_we_o), 16'h0000);
    @(negedge clock_i);
    check(16'({done_o, flags_we_o}), 16'h0002);
    check(pc_next_o, 16'h0203);
    @(negedge clock_i);
    start_i = 1'b0;
    check(16'({done_o, flags_we_o}), 16'h0003);
    check(16'(status_flags_o), 16'h0002);
    check(pc_next_o, 16'h0201);
    // Reset in mid-run clears every output at once
    rst_n_i = 1'b0;
    @(negedge clock_i);
    check(pc_next_o, 16'h0000);
    check(16'({busy_o, done_o, taken_o, flags_we_o, status_flags_o}), 16'h0000);
    rst_n_i = 1'b1;
    run(5'h0C, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05, 16'h0300, 1'b0, 8'h01);
    end_of_test();
  end

  initial begin
    #1000000;
    num_errors++;
    end_of_test();
  end
endmodule // tb_top
